// ===== tap_regs.vh
`ifndef TAP_REGS_VH
`define TAP_REGS_VH
// Instruction register
`define IR_WIDTH 3
`define INS_EXTERNAL_TEST 3'h0
`define INS_IDENT 3'h1
`define INS_SAMPLE_HIGHZ 3'h2
`define INS_SAMPLE_PRELOAD 3'h4
`define INS_BYPASS 3'h7
`define IR_CAPTURE_VALUE 3'h1
// Identification fields
`define ID_WIDTH 32
`define ID_REV_MSB 31
`define ID_REV_LSB 29
`define ID_PART_MSB 28
`define ID_PART_LSB 12
`define ID_MAKER_MSB 11
`define ID_MAKER_LSB 1
`define ID_PRESENT_BIT 0
// Boundary scan register
`define BSR_LENGTH 109
`define BSR_OE_CELL 108
// Controller states
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SHIFT_IR 4'hB
`define ST_EXIT1_IR 4'hC
`define ST_PAUSE_IR 4'hD
`define ST_EXIT2_IR 4'hE
`define ST_UPD_IR 4'hF
`endif

// ===== pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 3
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync,
	output wire [WIDTH-1:0] o_rise,
	output wire [WIDTH-1:0] o_fall
);
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	reg [WIDTH-1:0] stable_q;
	reg [WIDTH-1:0] prev_q;
	genvar g;

	////////////////////////////////////////////////////////////////////////
	// Three-stage sampling, accepted once stages two and three agree
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			s1_q <= {WIDTH{1'b0}};
			s2_q <= {WIDTH{1'b0}};
			s3_q <= {WIDTH{1'b0}};
			prev_q <= {WIDTH{1'b0}};
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			prev_q <= stable_q;
		end
	end

	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			always @(posedge i_core_clk) begin
				if (i_sys_rst) begin
					stable_q[g] <= 1'b0;
				end else if (s2_q[g] == s3_q[g]) begin
					stable_q[g] <= s3_q[g];
				end
			end
		end
	endgenerate

	assign o_sync = stable_q;
	assign o_rise = stable_q & ~prev_q;
	assign o_fall = ~stable_q & prev_q;
endmodule // pin_sync

// ===== scan_chain.v
`timescale 1ns/1ps
module scan_chain #(
	parameter LENGTH = 109
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_capture,
	input wire i_shift,
	input wire i_serial,
	input wire [LENGTH-1:0] i_parallel,
	output wire o_serial,
	output wire [LENGTH-1:0] o_chain
);
	reg [LENGTH-1:0] chain_q;

	////////////////////////////////////////////////////////////////////////
	// Capture or shift, MSB from serial in, LSB out
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			chain_q <= {LENGTH{1'b0}};
		end else if (i_capture) begin
			chain_q <= i_parallel;
		end else if (i_shift) begin
			chain_q <= {i_serial, chain_q[LENGTH-1:1]};
		end
	end

	assign o_serial = chain_q[0];
	assign o_chain = chain_q;
endmodule // scan_chain

// ===== boundary_scan_tap.v
`timescale 1ns/1ps
`include "tap_regs.vh"
module boundary_scan_tap #(
	// Arbitrary neutral values
	parameter [2:0] REVISION = 3'h3,
	parameter [16:0] PART_TYPE = 17'h0ABCD,
	parameter [10:0] MAKER_CODE = 11'h155,
	parameter BSR_LEN = `BSR_LENGTH
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_tck,
	input wire i_tms,
	input wire i_tdi,
	input wire [BSR_LEN-2:0] i_ring,
	output reg o_tdo,
	output reg o_tdo_oe,
	output wire o_out_drive_en,
	output wire o_extest_active,
	output wire [BSR_LEN-2:0] o_preload,
	output wire [`IR_WIDTH-1:0] o_instruction
);
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire tck_rise;
	wire tck_fall;
	wire [2:0] rise_v;
	wire [2:0] fall_v;
	wire bsr_out;
	wire [BSR_LEN-1:0] bsr_chain;
	wire [`ID_WIDTH-1:0] id_value;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [`IR_WIDTH-1:0] ir_shift_q;
	reg [`IR_WIDTH-1:0] ir_q;
	reg bypass_q;
	reg [`ID_WIDTH-1:0] id_q;
	reg [BSR_LEN-1:0] upd_q;
	reg serial_d;

	////////////////////////////////////////////////////////////////////////
	// Pin sampling
	pin_sync #(
		.WIDTH(3)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_tdi, i_tms, i_tck}),
		.o_sync({tdi_s, tms_s, tck_s}),
		.o_rise(rise_v),
		.o_fall(fall_v)
	);
	assign tck_rise = rise_v[0];
	assign tck_fall = fall_v[0];

	////////////////////////////////////////////////////////////////////////
	// Path selection
	function bsr_selected;
		input [`IR_WIDTH-1:0] code;
		begin
			bsr_selected = (code == `INS_EXTERNAL_TEST) || (code == `INS_SAMPLE_HIGHZ) ||
				(code == `INS_SAMPLE_PRELOAD);
		end
	endfunction

	function is_state;
		input [3:0] st;
		input [3:0] want;
		begin
			is_state = (st == want);
		end
	endfunction

	assign id_value = {REVISION, PART_TYPE, MAKER_CODE, 1'b1};

	////////////////////////////////////////////////////////////////////////
	// Controller next state
	always @* begin
		case (state_q)
			`ST_RESET: state_d = tms_s ? `ST_RESET : `ST_IDLE;
			`ST_IDLE: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR: state_d = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR: state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: state_d = tms_s ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: state_d = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: state_d = tms_s ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR: state_d = tms_s ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR: state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: state_d = tms_s ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: state_d = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: state_d = tms_s ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
			default: state_d = `ST_RESET;
		endcase
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q <= `ST_RESET;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction register
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ir_shift_q <= `INS_IDENT;
			ir_q <= `INS_IDENT;
		end else if (is_state(state_q, `ST_RESET)) begin
			ir_q <= `INS_IDENT;
			ir_shift_q <= `INS_IDENT;
		end else if (tck_rise) begin
			if (is_state(state_q, `ST_CAP_IR)) begin
				ir_shift_q <= `IR_CAPTURE_VALUE;
			end else if (is_state(state_q, `ST_SHIFT_IR)) begin
				ir_shift_q <= {tdi_s, ir_shift_q[`IR_WIDTH-1:1]};
			end
		end else if (tck_fall && is_state(state_q, `ST_UPD_IR)) begin
			// Reserved codes are assumed never loaded; they act as bypass
			ir_q <= ir_shift_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bypass and identification registers
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			bypass_q <= 1'b0;
			id_q <= {`ID_WIDTH{1'b0}};
		end else if (tck_rise) begin
			if (is_state(state_q, `ST_CAP_DR)) begin
				bypass_q <= 1'b0;
				if (ir_q == `INS_IDENT) begin
					id_q <= id_value;
				end
			end else if (is_state(state_q, `ST_SHIFT_DR)) begin
				bypass_q <= tdi_s;
				if (ir_q == `INS_IDENT) begin
					id_q <= {tdi_s, id_q[`ID_WIDTH-1:1]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Boundary scan register, cell 108 is internal enable
	scan_chain #(
		.LENGTH(BSR_LEN)
	) u_bsr (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_capture(tck_rise && is_state(state_q, `ST_CAP_DR) && bsr_selected(ir_q)),
		.i_shift(tck_rise && is_state(state_q, `ST_SHIFT_DR) && bsr_selected(ir_q)),
		.i_serial(tdi_s),
		.i_parallel({upd_q[`BSR_OE_CELL], i_ring}),
		.o_serial(bsr_out),
		.o_chain(bsr_chain)
	);

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			upd_q <= {1'b1, {(BSR_LEN-1){1'b0}}};
		end else if (is_state(state_q, `ST_RESET)) begin
			upd_q[`BSR_OE_CELL] <= 1'b1;
		end else if (tck_fall && is_state(state_q, `ST_UPD_DR) && bsr_selected(ir_q)) begin
			upd_q <= bsr_chain;
		end
	end

	assign o_preload = upd_q[BSR_LEN-2:0];
	assign o_extest_active = (ir_q == `INS_EXTERNAL_TEST);
	assign o_out_drive_en = (ir_q == `INS_SAMPLE_HIGHZ) ? 1'b0 :
		(o_extest_active ? upd_q[`BSR_OE_CELL] : 1'b1);
	assign o_instruction = ir_q;

	////////////////////////////////////////////////////////////////////////
	// Serial output, updated on clock fall
	always @* begin
		serial_d = bypass_q;
		if (is_state(state_q, `ST_SHIFT_IR)) begin
			serial_d = ir_shift_q[0];
		end else if (ir_q == `INS_IDENT) begin
			serial_d = id_q[0];
		end else if (bsr_selected(ir_q)) begin
			serial_d = bsr_out;
		end
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_tdo <= 1'b0;
			o_tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			o_tdo <= serial_d;
			o_tdo_oe <= is_state(state_q, `ST_SHIFT_IR) || is_state(state_q, `ST_SHIFT_DR);
		end
	end
endmodule // boundary_scan_tap

// ===== boundary_scan_tap_properties.sv
`timescale 1ns/1ps
`include "tap_regs.vh"
module boundary_scan_tap_properties #(
	parameter BSR_LEN = 109
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_tck,
	input wire i_tms,
	input wire i_tdi,
	input wire [BSR_LEN-2:0] i_ring,
	input wire o_tdo,
	input wire o_tdo_oe,
	input wire o_out_drive_en,
	input wire o_extest_active,
	input wire [BSR_LEN-2:0] o_preload,
	input wire [2:0] o_instruction
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	property p_tdo_fall;
		$changed(o_tdo) |-> !$past(i_tck, 2);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved in high phase");
	property p_tdo_hold;
		$changed(o_tdo) |=> $stable(o_tdo)[*7];
	endproperty
	a_tdo_hold: assert property (p_tdo_hold) else $error("tdo not held");
	property p_oe_fall;
		$changed(o_tdo_oe) |-> !$past(i_tck, 2);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved in high phase");
	property p_extest;
		o_extest_active == (o_instruction == `INS_EXTERNAL_TEST);
	endproperty
	a_extest: assert property (p_extest) else $error("extest flag wrong");
	property p_highz;
		o_instruction == `INS_SAMPLE_HIGHZ |-> !o_out_drive_en;
	endproperty
	a_highz: assert property (p_highz) else $error("bus not floated");
	property p_drive;
		!(o_instruction inside {3'h0, 3'h2}) |-> o_out_drive_en;
	endproperty
	a_drive: assert property (p_drive) else $error("bus disturbed");
	property p_rst;
		$past(i_sys_rst) |-> o_instruction == `INS_IDENT && !o_tdo && !o_tdo_oe
			&& o_out_drive_en && o_preload == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_ins_quiet;
		$changed(o_instruction) |-> !o_tdo_oe;
	endproperty
	a_ins_quiet: assert property (p_ins_quiet) else $error("instruction moved in shift");
	property p_oe_hold;
		$changed(o_tdo_oe) |=> $stable(o_tdo_oe)[*7];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("tdo enable not held");
	property p_preload_quiet;
		$changed(o_preload) |-> !o_tdo_oe && (o_instruction inside {`INS_EXTERNAL_TEST,
			`INS_SAMPLE_HIGHZ, `INS_SAMPLE_PRELOAD});
	endproperty
	a_preload_quiet: assert property (p_preload_quiet) else $error("preload moved");
	property p_drive_quiet;
		$changed(o_out_drive_en) |-> !o_tdo_oe;
	endproperty
	a_drive_quiet: assert property (p_drive_quiet) else $error("drive moved in shift");
endmodule // boundary_scan_tap_properties
bind boundary_scan_tap boundary_scan_tap_properties #(.BSR_LEN(BSR_LEN)) i_props (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_tck(i_tck), .i_tms(i_tms),
	.i_tdi(i_tdi), .i_ring(i_ring), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
	.o_out_drive_en(o_out_drive_en), .o_extest_active(o_extest_active),
	.o_preload(o_preload), .o_instruction(o_instruction));

// ===== jtag_ctrl.sv
`timescale 1ns/1ps
module jtag_ctrl (
	input wire i_core_clk,
	input wire i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	// Idle levels, clock low and mode high
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// One test clock, sampled before the fall
	task step(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		repeat (4) @(negedge i_core_clk);
		o_tck = 1'b1;
		repeat (4) @(negedge i_core_clk);
		tdo = i_tdo;
		o_tck = 1'b0;
	endtask
	// Idle to idle scan of n bits
	task scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic b;
		int pz;
		dout = '0;
		pz = ir ? n : n / 2;
		step(1'b1, o_tdi, b);
		if (ir) step(1'b1, o_tdi, b);
		step(1'b0, o_tdi, b);
		step(1'b0, o_tdi, b);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pz, din[i], b);
			dout[i] = b;
			// Data scans pause once midway
			if (i == pz && i != n - 1) begin
				step(1'b0, din[i], b);
				step(1'b1, din[i], b);
				step(1'b0, din[i], b);
			end
		end
		step(1'b1, ~din[n-1], b);
		step(1'b0, ~din[n-1], b);
	endtask
endmodule // jtag_ctrl

// ===== boundary_scan_tap_tb_top.sv
`timescale 1ns/1ps
`include "tap_regs.vh"
module boundary_scan_tap_tb_top;
	localparam [2:0] REV = 3'h5;
	// Arbitrary neutral values
	localparam [16:0] PART = 17'h1C3A5;
	localparam [10:0] MAKER = 11'h2B6;
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [107:0] i_ring = '0;
	wire tck, tms, tdi, tdo, oe, drv, ext;
	wire [107:0] pre;
	wire [2:0] ins;
	int miscompares = 0;
	int n_checks = 0;
	int n;
	int oe_hi = 0;
	int oe_mark;
	logic exp_drv;
	logic [15:0] lfsr = 16'h138C;
	logic oe_cell = 1'b1;
	logic b;
	logic [2:0] code;
	logic [127:0] din, dout, ring_r, mask;
	// Defined codes only
	logic [2:0] codes [5] = '{`INS_SAMPLE_PRELOAD, `INS_EXTERNAL_TEST, `INS_SAMPLE_HIGHZ,
		`INS_BYPASS, `INS_IDENT};
	always #12.5 i_core_clk = ~i_core_clk;
	// Counts clock cycles with the serial output enabled
	always @(negedge i_core_clk) begin
		if (oe) oe_hi <= oe_hi + 1;
	end
	jtag_ctrl i_jtag_ctrl (.i_core_clk(i_core_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms),
		.o_tdi(tdi));
	boundary_scan_tap #(.REVISION(REV), .PART_TYPE(PART), .MAKER_CODE(MAKER)) i_boundary_scan_tap (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_ring(i_ring), .o_tdo(tdo), .o_tdo_oe(oe), .o_out_drive_en(drv),
		.o_extest_active(ext), .o_preload(pre), .o_instruction(ins));
	////////////////////////////////////////////////////////////////
	function automatic logic [127:0] rnd();
		for (int i = 0; i < 8; i++) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			rnd = {rnd[111:0], lfsr};
		end
	endfunction
	function automatic logic [127:0] exp_dr(input logic [2:0] c, input logic [127:0] d, r,
		input logic oc);
		case (c)
			`INS_IDENT: exp_dr = {96'h0, REV, PART, MAKER, 1'b1};
			`INS_BYPASS: exp_dr = {d[126:0], 1'b0};
			default: exp_dr = {19'h0, oc, r[107:0]};
		endcase
	endfunction
	task chk(input logic [127:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task close_out();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge i_core_clk);
		miscompares++;
		close_out();
	end
	initial begin
		repeat (10) @(negedge i_core_clk);
		i_sys_rst = 1'b0;
		repeat (6) @(negedge i_core_clk);
		chk(ins, `INS_IDENT);
		chk(drv, 1'b1);
		i_jtag_ctrl.step(1'b0, 1'b0, b);
		foreach (codes[k]) begin
			code = codes[k];
			i_jtag_ctrl.scan(1'b1, 3, {125'h0, code}, dout);
			chk(dout[2:0], `INS_IDENT);
			chk(ins, code);
			chk(ext, code == `INS_EXTERNAL_TEST);
			exp_drv = code == `INS_SAMPLE_HIGHZ ? 1'b0 :
				(code == `INS_EXTERNAL_TEST ? oe_cell : 1'b1);
			chk(drv, exp_drv);
			ring_r = rnd();
			@(negedge i_core_clk) i_ring = ring_r[107:0];
			din = rnd();
			din[108] = k[0];
			n = code == `INS_IDENT ? 32 : code == `INS_BYPASS ? 8 : 109;
			oe_mark = oe_hi;
			i_jtag_ctrl.scan(1'b0, n, din, dout);
			chk(oe_hi - oe_mark, 8 * n);
			mask = (128'h1 << n) - 128'h1;
			chk(dout & mask, exp_dr(code, din, ring_r, oe_cell) & mask);
			if (n == 109) begin
				chk(pre, din[107:0]);
				oe_cell = din[108];
			end
		end
		i_jtag_ctrl.scan(1'b1, 3, {125'h0, `INS_EXTERNAL_TEST}, dout);
		chk(drv, oe_cell);
		repeat (5) i_jtag_ctrl.step(1'b1, 1'b0, b);
		repeat (4) @(negedge i_core_clk);
		chk(ins, `INS_IDENT);
		chk(drv, 1'b1);
		i_jtag_ctrl.scan(1'b1, 3, {125'h0, `INS_EXTERNAL_TEST}, dout);
		chk(drv, 1'b1);
		close_out();
	end
endmodule // boundary_scan_tap_tb_top
